// File: src/resolver_pkg.sv
/*
  Shared constants for the resolver serial link, pin straps and the
  controller register map.
  Assumes a 200 MHz reference clock on both ends.
*/
package resolver_pkg;
  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 32;
  localparam int CRC_W = 6;
  localparam logic [5:0] CRC_POLY = 6'h03;
  localparam logic [5:0] CRC_INIT = 6'h3f;
  localparam logic [15:0] DUMMY_DATA = 16'h00f0;
  // ----------------------------------------------------------------
  // Device address codes, read and write kept distinct
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_WR_FIRST = 8'h87;
  localparam logic [7:0] ADDR_RD_FIRST = 8'h53;
  localparam logic [7:0] ADDR_RD_SECOND = 8'h6b;
  localparam logic [7:0] ADDR_WR_SECOND = 8'h95;
  localparam logic [7:0] ADDR_WR_UNLOCK = 8'h56;
  localparam logic [7:0] ADDR_RD_STATUS = 8'he1;
  localparam logic [15:0] UNLOCK_KEY = 16'h000b;
  localparam logic [15:0] CFG_FIRST_RST = 16'h0000;
  localparam logic [15:0] CFG_SECOND_RST = 16'h0000;
  localparam int ST_FAULT = 0;
  localparam int ST_CRCERR = 1;
  localparam int ST_UNLOCK = 2;
  localparam int ST_RES12 = 3;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int REF_MHZ = 200;
  localparam int SPI_FMAX_MHZ = 8;
  localparam int SPI_HALF_CYC = (REF_MHZ + 2 * SPI_FMAX_MHZ - 1) / (2 * SPI_FMAX_MHZ);
  localparam int STROBE_HALF = 8;
  // ----------------------------------------------------------------
  // Device pin sample vector
  // ----------------------------------------------------------------
  localparam int NPIN = 12;
  localparam int P_CS = 0;
  localparam int P_SCLK = 1;
  localparam int P_SDI = 2;
  localparam int P_CLKSEL = 3;
  localparam int P_ERRCLR = 4;
  localparam int P_RES = 5;
  localparam int P_ACCEL = 6;
  localparam int P_RSTN = 7;
  localparam int P_HOLDN = 8;
  localparam int P_FMT = 9;
  localparam int P_VLO = 10;
  localparam int P_VHI = 11;
  localparam logic [11:0] PIN_IDLE = 12'h191;
  // ----------------------------------------------------------------
  // Controller registers
  // ----------------------------------------------------------------
  localparam logic [7:0] HOFS_CMD = 8'h00;
  localparam logic [7:0] HOFS_STAT = 8'h04;
  localparam logic [7:0] HOFS_RESP = 8'h08;
  localparam logic [7:0] HOFS_PINS = 8'h0c;
  localparam int CMD_RD_BIT = 24;
  localparam int HST_BUSY = 0;
  localparam int HST_CRCERR = 1;
  localparam int HST_FAULT = 2;
  localparam logic [8:0] PINS_RST = 9'h032;
endpackage

// File: src/resolver_link_if.sv
/*
  Pin bundle between the resolver converter and its host controller.
  Assumes the bench joins one device end and one host end to it.
*/
`timescale 1ns/1ps
interface resolver_link_if;
  logic chip_select_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic clock_source_select;
  logic error_clear_in;
  logic resolution_select;
  logic accel_tracking_select;
  logic reset_n;
  logic output_hold_n;
  logic output_format_select;
  logic value_select_lo;
  logic value_select_hi;
  logic fault_drive;
  logic fault_drive_oe_n;
  logic fault_level;
  logic parity_out;
  logic quadrature_a_out;
  logic quadrature_b_out;
  logic index_pulse_out;
  logic [13:0] parallel_word_out;

  // Host side pull-up on the open-collector fault line
  assign fault_level = fault_drive_oe_n ? 1'b1 : fault_drive;

  modport dev(
    input chip_select_n, sclk, sdi, clock_source_select, error_clear_in,
    input resolution_select, accel_tracking_select, reset_n, output_hold_n,
    input output_format_select, value_select_lo, value_select_hi,
    output sdo, fault_drive, fault_drive_oe_n, parity_out,
    output quadrature_a_out, quadrature_b_out, index_pulse_out, parallel_word_out
  );
  modport host(
    output chip_select_n, sclk, sdi, clock_source_select, error_clear_in,
    output resolution_select, accel_tracking_select, reset_n, output_hold_n,
    output output_format_select, value_select_lo, value_select_hi,
    input sdo, fault_level, parity_out,
    input quadrature_a_out, quadrature_b_out, index_pulse_out, parallel_word_out
  );
endinterface

// File: src/crc6_calc.sv
/*
  Combinational 6-bit CRC over the 24 leading frame bits, MSB first.
  Assumes polynomial and start value agree on both ends.
*/
`timescale 1ns/1ps
module crc6_calc #(
  parameter logic [5:0] POLY = resolver_pkg::CRC_POLY,
  parameter logic [5:0] INIT = resolver_pkg::CRC_INIT
) (
  input wire logic [23:0] i_data,
  output logic [5:0] o_crc
);
  // Bitwise serial form, unrolled by the loop
  always_comb begin
    logic [5:0] c;
    logic fb;
    c = INIT;
    fb = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      fb = c[5] ^ i_data[i];
      c = {c[4:0], 1'b0} ^ (fb ? POLY : 6'h00);
    end
    o_crc = c;
  end
endmodule

// File: src/resolver_device.sv
/*
  Digital face of the resolver converter: serial register port, strap
  pins, fault line and parallel/encoder outputs.
  Assumes the pins are asynchronous to i_ref_clk and the measurement
  inputs come from logic on i_ref_clk.
*/
// Contract
// - Host keeps serial clock at most 8 MHz
// - Chip select high: serial activity ignored
// - Clock idles low, data sampled falling
// - Address byte alone gives read/write
// - Frames need valid CRC over three bytes
// - Frame: address, 16-bit data, CRC byte
// - Shifted most significant byte first
// - Response holds previously addressed register
// - Host reads via two identical dummy frames
// - Locked registers need unlock before change
// - Clock select low picks internal oscillator
// - Falling fault-clear clears latched faults
// - Fault-clear held low masks fault output
// - Resolution select: low 10-bit, high 12-bit
// - Acceleration input high enables fast tracking
// - Fault line pulled low when healthy
// - Parity output covers presented data word
// - Reset pin low holds device reset
// - Output hold low freezes parallel word
// - Format select enables encoder emulation
// - Value selects choose angle or velocity
// - Parallel bits 0-11 data, 13 strobe
// - Host configures over serial port always; here clock source, resolution, tracking and output modes come from strap pins
`timescale 1ns/1ps
module resolver_device #(
  parameter int STB_HALF = resolver_pkg::STROBE_HALF
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  resolver_link_if.dev link,
  input wire logic [11:0] i_angle,
  input wire logic [11:0] i_velocity,
  input wire logic i_fault_event,
  output logic o_internal_osc_sel,
  output logic o_accel_track_en,
  output logic o_res_12b,
  output logic o_core_reset,
  output logic [15:0] o_supply_limit_first,
  output logic [15:0] o_supply_limit_second
);
  typedef struct packed {
    logic [11:0] s1;
    logic [11:0] s2;
    logic [11:0] s3;
    logic [11:0] filt;
    logic [31:0] rx;
    logic [31:0] tx;
    logic [5:0] bits;
    logic sdo;
    logic [7:0] ptr;
    logic unlocked;
    logic [15:0] cfg1;
    logic [15:0] cfg2;
    logic crc_err;
    logic fault_lat;
    logic fault_oe_n;
    logic [11:0] word;
    logic strobe;
    logic [7:0] stb_cnt;
    logic parity;
    logic qa;
    logic qb;
    logic qz;
    logic osc_int;
    logic accel;
    logic res12;
    logic core_rst;
  } dev_state_t;

  localparam dev_state_t DEV_RST = '{
    s1: resolver_pkg::PIN_IDLE,
    s2: resolver_pkg::PIN_IDLE,
    s3: resolver_pkg::PIN_IDLE,
    filt: resolver_pkg::PIN_IDLE,
    cfg1: resolver_pkg::CFG_FIRST_RST,
    cfg2: resolver_pkg::CFG_SECOND_RST,
    osc_int: 1'b1,
    default: '0
  };

  dev_state_t q;
  dev_state_t n;
  logic [15:0] rsp_data;
  logic [5:0] rsp_crc;
  logic [5:0] rx_crc;

  // ----------------------------------------------------------------
  // Response word for the register pointed at by the last frame
  // ----------------------------------------------------------------
  always_comb begin
    rsp_data = 16'h0000;
    case (q.ptr)
      resolver_pkg::ADDR_WR_FIRST, resolver_pkg::ADDR_RD_FIRST: begin
        rsp_data = q.cfg1;
      end
      resolver_pkg::ADDR_WR_SECOND, resolver_pkg::ADDR_RD_SECOND: begin
        rsp_data = q.cfg2;
      end
      resolver_pkg::ADDR_RD_STATUS: begin
        rsp_data[resolver_pkg::ST_FAULT] = q.fault_lat;
        rsp_data[resolver_pkg::ST_CRCERR] = q.crc_err;
        rsp_data[resolver_pkg::ST_UNLOCK] = q.unlocked;
        rsp_data[resolver_pkg::ST_RES12] = q.res12;
      end
      default: begin
        rsp_data = 16'h0000;
      end
    endcase
  end

  crc6_calc u_rsp_crc (
    .i_data({q.ptr, rsp_data}),
    .o_crc(rsp_crc)
  );

  crc6_calc u_rx_crc (
    .i_data(q.rx[31:8]),
    .o_crc(rx_crc)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [11:0] nf;
    logic [11:0] sel;
    logic [1:0] enc;
    logic [7:0] addr;
    logic [15:0] data;
    n = q;
    // Three-stage capture; a level moves once stages two and three agree
    n.s1 = {link.value_select_hi, link.value_select_lo, link.output_format_select,
            link.output_hold_n, link.reset_n, link.accel_tracking_select,
            link.resolution_select, link.error_clear_in, link.clock_source_select,
            link.sdi, link.sclk, link.chip_select_n};
    n.s2 = q.s1;
    n.s3 = q.s2;
    nf = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.filt);
    n.filt = nf;
    addr = q.rx[31:24];
    data = q.rx[23:8];
    sel = 12'h000;
    enc = 2'b00;

    // Serial port
    if (nf[resolver_pkg::P_CS]) begin
      n.bits = 6'd0;
    end else if (q.filt[resolver_pkg::P_CS]) begin
      n.tx = {q.ptr, rsp_data, 2'b00, rsp_crc};
      n.bits = 6'd0;
    end else begin
      if (nf[resolver_pkg::P_SCLK] && !q.filt[resolver_pkg::P_SCLK]) begin
        n.sdo = q.tx[31]; // Launch on rise
        n.tx = {q.tx[30:0], 1'b0};
      end
      if (!nf[resolver_pkg::P_SCLK] && q.filt[resolver_pkg::P_SCLK]
          && q.bits != 6'(resolver_pkg::FRAME_BITS)) begin
        n.rx = {q.rx[30:0], nf[resolver_pkg::P_SDI]}; // Capture on fall
        n.bits = q.bits + 6'd1;
      end
    end

    // Frame end: only a full frame with a good checksum acts
    if (nf[resolver_pkg::P_CS] && !q.filt[resolver_pkg::P_CS]
        && q.bits == 6'(resolver_pkg::FRAME_BITS)) begin
      if (rx_crc != q.rx[5:0]) begin
        n.crc_err = 1'b1;
      end else begin
        n.ptr = addr;
        case (addr)
          resolver_pkg::ADDR_WR_FIRST: begin
            if (q.unlocked) begin
              n.cfg1 = data;
            end
          end
          resolver_pkg::ADDR_WR_SECOND: begin
            if (q.unlocked) begin
              n.cfg2 = data;
            end
          end
          resolver_pkg::ADDR_WR_UNLOCK: begin
            n.unlocked = (data == resolver_pkg::UNLOCK_KEY);
          end
          default: begin
            n.ptr = addr;
          end
        endcase
      end
    end

    // Straps
    n.osc_int = !nf[resolver_pkg::P_CLKSEL];
    n.res12 = nf[resolver_pkg::P_RES];
    n.accel = nf[resolver_pkg::P_ACCEL];

    // Fault latch: a new event wins over a clear in the same cycle
    if (i_fault_event) begin
      n.fault_lat = 1'b1;
    end else if (!nf[resolver_pkg::P_ERRCLR] && q.filt[resolver_pkg::P_ERRCLR]) begin
      n.fault_lat = 1'b0;
    end
    // Released line means a reported fault; clear held low masks it
    n.fault_oe_n = n.fault_lat & nf[resolver_pkg::P_ERRCLR];

    // Parallel word, refreshed as the strobe falls
    if (nf[resolver_pkg::P_VHI]) begin
      sel = 12'h000;
    end else if (nf[resolver_pkg::P_VLO]) begin
      sel = i_velocity;
    end else begin
      sel = i_angle;
    end
    if (!n.res12) begin
      sel[1:0] = 2'b00;
    end
    if (q.stb_cnt == 8'(STB_HALF - 1)) begin
      n.stb_cnt = 8'd0;
      n.strobe = !q.strobe;
      if (q.strobe && nf[resolver_pkg::P_HOLDN]) begin
        n.word = sel;
        n.parity = ^sel;
      end
    end else begin
      n.stb_cnt = q.stb_cnt + 8'd1;
    end

    // Encoder emulation from the two lowest live angle bits
    enc = n.res12 ? i_angle[1:0] : i_angle[3:2];
    if (nf[resolver_pkg::P_FMT]) begin
      n.qa = enc[1];
      n.qb = enc[1] ^ enc[0];
      n.qz = (i_angle == 12'h000);
    end else begin
      n.qa = 1'b0;
      n.qb = 1'b0;
      n.qz = 1'b0;
    end

    // Reset pin holds the core; capture stages keep running
    n.core_rst = !nf[resolver_pkg::P_RSTN];
    if (!nf[resolver_pkg::P_RSTN]) begin
      n = '{s1: n.s1, s2: n.s2, s3: n.s3, filt: n.filt, cfg1: DEV_RST.cfg1,
            cfg2: DEV_RST.cfg2, osc_int: n.osc_int, core_rst: 1'b1,
            default: '0};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      q <= DEV_RST;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.sdo = q.sdo;
  assign link.fault_drive = 1'b0;
  assign link.fault_drive_oe_n = q.fault_oe_n;
  assign link.parity_out = q.parity;
  assign link.quadrature_a_out = q.qa;
  assign link.quadrature_b_out = q.qb;
  assign link.index_pulse_out = q.qz;
  assign link.parallel_word_out = {q.strobe, 1'b0, q.word};
  assign o_internal_osc_sel = q.osc_int;
  assign o_accel_track_en = q.accel;
  assign o_res_12b = q.res12;
  assign o_core_reset = q.core_rst;
  assign o_supply_limit_first = q.cfg1;
  assign o_supply_limit_second = q.cfg2;
endmodule

// File: src/resolver_host.sv
/*
  Host controller for the resolver link: software command registers,
  serial frame master and strap pin drivers.
  Assumes software on i_ref_clk and the device end on the link.
*/
`timescale 1ns/1ps
module resolver_host #(
  parameter int HALF = resolver_pkg::SPI_HALF_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  resolver_link_if.host link
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_LEAD = 6'b000010,
    ST_HIGH = 6'b000100,
    ST_LOW = 6'b001000,
    ST_TAIL = 6'b010000,
    ST_GAP = 6'b100000
  } host_st_t;

  typedef struct packed {
    host_st_t st;
    logic [7:0] tmr;
    logic [5:0] bits;
    logic [23:0] cmd;
    logic again;
    logic [31:0] tx;
    logic [31:0] rx;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic [8:0] pins;
    logic [15:0] resp;
    logic crc_err;
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] filt;
    logic [31:0] rdata;
  } host_state_t;

  localparam host_state_t HOST_RST = '{
    st: ST_IDLE,
    cs_n: 1'b1,
    pins: resolver_pkg::PINS_RST,
    default: '0
  };

  host_state_t q;
  host_state_t n;
  logic [5:0] tx_crc;
  logic [5:0] rx_crc;

  crc6_calc u_tx_crc (
    .i_data(q.cmd),
    .o_crc(tx_crc)
  );

  crc6_calc u_rx_crc (
    .i_data(q.rx[31:8]),
    .o_crc(rx_crc)
  );

  // ----------------------------------------------------------------
  // Frame sequencer and register port
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] frame;
    logic half_done;
    n = q;
    frame = {q.cmd, 2'b00, tx_crc};
    half_done = (q.tmr == 8'(HALF - 1));
    n.tmr = q.tmr + 8'd1;
    // Returning pins: [0] serial data, [1] fault level
    n.s1 = {link.fault_level, link.sdo};
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.filt = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.filt);
    n.rdata = 32'h0000_0000;

    case (q.st)
      ST_IDLE: begin
        n.tmr = 8'd0;
        if (i_wr && i_addr == resolver_pkg::HOFS_CMD) begin
          n.again = i_wdata[resolver_pkg::CMD_RD_BIT];
          n.cmd = {i_wdata[23:16],
                   n.again ? resolver_pkg::DUMMY_DATA : i_wdata[15:0]};
          n.cs_n = 1'b0;
          n.st = ST_LEAD;
        end
      end
      ST_LEAD: begin
        if (half_done) begin
          n.tmr = 8'd0;
          n.sclk = 1'b1;
          n.mosi = frame[31];
          n.tx = {frame[30:0], 1'b0};
          n.bits = 6'd0;
          n.st = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (half_done) begin
          n.tmr = 8'd0;
          n.sclk = 1'b0;
          n.rx = {q.rx[30:0], q.filt[0]}; // Sample on fall
          n.bits = q.bits + 6'd1;
          n.st = ST_LOW;
        end
      end
      ST_LOW: begin
        if (half_done) begin
          n.tmr = 8'd0;
          if (q.bits == 6'(resolver_pkg::FRAME_BITS)) begin
            n.st = ST_TAIL;
          end else begin
            n.sclk = 1'b1;
            n.mosi = q.tx[31];
            n.tx = {q.tx[30:0], 1'b0};
            n.st = ST_HIGH;
          end
        end
      end
      ST_TAIL: begin
        if (half_done) begin
          n.tmr = 8'd0;
          n.cs_n = 1'b1;
          n.mosi = 1'b0;
          n.resp = q.rx[23:8]; // First read answer is overwritten
          n.crc_err = (rx_crc != q.rx[5:0]);
          n.st = ST_GAP;
        end
      end
      ST_GAP: begin
        if (q.tmr == 8'(2 * HALF - 1)) begin
          n.tmr = 8'd0;
          if (q.again) begin
            n.again = 1'b0;
            n.cs_n = 1'b0; // Identical second frame
            n.st = ST_LEAD;
          end else begin
            n.st = ST_IDLE;
          end
        end
      end
      default: begin
        n = HOST_RST;
      end
    endcase

    if (i_wr && i_addr == resolver_pkg::HOFS_PINS) begin
      n.pins = i_wdata[8:0];
    end
    if (i_rd) begin
      case (i_addr)
        resolver_pkg::HOFS_STAT: begin
          n.rdata[resolver_pkg::HST_BUSY] = (q.st != ST_IDLE);
          n.rdata[resolver_pkg::HST_CRCERR] = q.crc_err;
          n.rdata[resolver_pkg::HST_FAULT] = q.filt[1];
        end
        resolver_pkg::HOFS_RESP: begin
          n.rdata[15:0] = q.resp;
        end
        resolver_pkg::HOFS_PINS: begin
          n.rdata[8:0] = q.pins;
        end
        default: begin
          n.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      q <= HOST_RST;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_rdata = q.rdata;
  assign link.chip_select_n = q.cs_n;
  assign link.sclk = q.sclk;
  assign link.sdi = q.mosi;
  assign link.clock_source_select = q.pins[0];
  assign link.error_clear_in = q.pins[1];
  assign link.resolution_select = q.pins[2];
  assign link.accel_tracking_select = q.pins[3];
  assign link.reset_n = q.pins[4];
  assign link.output_hold_n = q.pins[5];
  assign link.output_format_select = q.pins[6];
  assign link.value_select_lo = q.pins[7];
  assign link.value_select_hi = q.pins[8];
endmodule

// File: verif/resolver_link_chk.sv
/*
  Checker on the link between the device and host ends.
  Assumes the bench hands it the interface signals and the shared clock.
*/
`timescale 1ns/1ps
module resolver_link_chk (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic error_clear_in,
  input wire logic reset_n,
  input wire logic output_hold_n,
  input wire logic output_format_select,
  input wire logic fault_drive_oe_n,
  input wire logic parity_out,
  input wire logic quadrature_a_out,
  input wire logic quadrature_b_out,
  input wire logic index_pulse_out,
  input wire logic [13:0] parallel_word_out
);
  // ----------------------------------------------------------------
  // Falling serial clock edges within one frame
  // ----------------------------------------------------------------
  logic sclk_reg;
  logic [5:0] falls_reg;
  // Cycles the serial clock has held its level, saturating
  logic [7:0] level_cnt_reg;
  always_ff @(posedge i_ref_clk) begin
    sclk_reg <= sclk;
    if (i_srst || sclk_reg != sclk) begin
      level_cnt_reg <= 8'h00;
    end else if (level_cnt_reg != 8'hff) begin
      level_cnt_reg <= level_cnt_reg + 8'h01;
    end
    if (i_srst || chip_select_n) begin
      falls_reg <= 6'h00;
    end else if (sclk_reg && !sclk) begin
      falls_reg <= falls_reg + 6'h01;
    end
  end

  // Pin reset parks every link output, so its span is left out
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst || !reset_n);

  AST_CLK_IDLE: assert property (chip_select_n |-> !sclk)
    else $error("serial clock not idle low");
  // A count of 12 means 13 clocks at one level, at least 65 ns
  AST_SCLK_HALF: assert property ($changed(sclk) |-> level_cnt_reg >= 8'h0c)
    else $error("serial clock half period too short");
  AST_SDI_SETTLED: assert property ($fell(sclk) |-> $stable(sdi))
    else $error("sdi moved at falling clock");
  AST_SDO_SETTLED: assert property ($fell(sclk) |-> $stable(sdo))
    else $error("sdo moved at falling clock");
  AST_FRAME_LEN: assert property ($rose(chip_select_n) |-> falls_reg == 6'h20)
    else $error("frame not 32 bits");
  AST_BIT12: assert property (parallel_word_out[12] == 1'b0)
    else $error("unused parallel bit driven");
  AST_PARITY: assert property (parity_out == ^parallel_word_out[11:0])
    else $error("parity mismatch");
  AST_STROBE: assert property ($changed(parallel_word_out[13]) |=>
    $stable(parallel_word_out[13]) [*7] ##1 $changed(parallel_word_out[13]))
    else $error("strobe period wrong");
  AST_HOLD: assert property (!output_hold_n [*8] |-> $stable(parallel_word_out[11:0]))
    else $error("held word changed");
  AST_QUAD_OFF: assert property (!output_format_select [*8] |->
    !(quadrature_a_out || quadrature_b_out || index_pulse_out))
    else $error("encoder outputs active");
  AST_FAULT_MASK: assert property (!error_clear_in [*8] |-> !fault_drive_oe_n)
    else $error("fault shown while masked");
endmodule

// File: verif/resolver_host_interface_tb.sv
/*
  Bench joining host and device ends over the link interface.
  Assumes software-port timing of the host and the pin map of PINS.
*/
`timescale 1ns/1ps
module resolver_host_interface_tb;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [11:0] angle = 12'h000;
  logic [11:0] velocity = 12'h567;
  logic fault_ev = 1'b0;
  logic osc_sel, accel_en, res_12b, core_rst;
  logic [15:0] lim_first, lim_second;
  logic [31:0] v;
  int miscompares = 0;
  int checks_done = 0;

  always #2.5 ref_clk = ~ref_clk;

  resolver_link_if lnk();
  resolver_device resolver_device_i (.i_ref_clk(ref_clk), .i_srst(srst), .link(lnk),
    .i_angle(angle), .i_velocity(velocity), .i_fault_event(fault_ev),
    .o_internal_osc_sel(osc_sel), .o_accel_track_en(accel_en), .o_res_12b(res_12b),
    .o_core_reset(core_rst), .o_supply_limit_first(lim_first),
    .o_supply_limit_second(lim_second));
  resolver_host resolver_host_i (.i_ref_clk(ref_clk), .i_srst(srst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .link(lnk));
  resolver_link_chk resolver_link_chk_i (.i_ref_clk(ref_clk), .i_srst(srst),
    .chip_select_n(lnk.chip_select_n), .sclk(lnk.sclk), .sdi(lnk.sdi), .sdo(lnk.sdo),
    .error_clear_in(lnk.error_clear_in), .reset_n(lnk.reset_n),
    .output_hold_n(lnk.output_hold_n), .output_format_select(lnk.output_format_select),
    .fault_drive_oe_n(lnk.fault_drive_oe_n), .parity_out(lnk.parity_out),
    .quadrature_a_out(lnk.quadrature_a_out), .quadrature_b_out(lnk.quadrature_b_out),
    .index_pulse_out(lnk.index_pulse_out), .parallel_word_out(lnk.parallel_word_out));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Polls busy; a read command runs two frames before it drops
  task frame(input logic [31:0] c);
    wreg(resolver_pkg::HOFS_CMD, c);
    for (int i = 0; i < 3000; i++) begin
      rreg(resolver_pkg::HOFS_STAT, v);
      if (v[0] === 1'b0) break;
    end
    chk({31'h0, v[0]}, 32'h0);
  endtask
  task settle;
    repeat (40) @(posedge ref_clk);
  endtask
  // Straps pass a synchroniser and the word moves with the strobe
  task pins(input logic [8:0] p);
    wreg(resolver_pkg::HOFS_PINS, {23'h0, p});
    settle;
  endtask
  task pulse;
    fault_ev <= 1'b1;
    @(posedge ref_clk);
    fault_ev <= 1'b0;
    settle;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    rreg(resolver_pkg::HOFS_PINS, v);
    chk(v, 32'h032);
    chk({31'h0, osc_sel}, 32'h1);
    chk({lim_second, lim_first}, 32'h0);
  endtask
  task t_lock;
    frame({8'h00, resolver_pkg::ADDR_WR_FIRST, 16'h8fc0});
    chk({16'h0, lim_first}, 32'h0);
    frame({8'h00, resolver_pkg::ADDR_WR_UNLOCK, resolver_pkg::UNLOCK_KEY});
    frame({8'h00, resolver_pkg::ADDR_WR_FIRST, 16'h8fc0});
    frame({8'h00, resolver_pkg::ADDR_WR_SECOND, 16'h1234});
    chk({16'h0, lim_first}, 32'h8fc0);
    chk({16'h0, lim_second}, 32'h1234);
    frame({8'h01, resolver_pkg::ADDR_RD_FIRST, 16'h0000});
    rreg(resolver_pkg::HOFS_RESP, v);
    chk({16'h0, v[15:0]}, 32'h8fc0);
    rreg(resolver_pkg::HOFS_STAT, v);
    chk({31'h0, v[1]}, 32'h0);
    frame({8'h01, resolver_pkg::ADDR_RD_STATUS, 16'h0000});
    rreg(resolver_pkg::HOFS_RESP, v);
    chk({16'h0, v[15:0]}, 32'h0004);
    frame({8'h01, resolver_pkg::ADDR_RD_SECOND, 16'h0000});
    rreg(resolver_pkg::HOFS_RESP, v);
    chk({16'h0, v[15:0]}, 32'h1234);
    frame({8'h00, resolver_pkg::ADDR_WR_UNLOCK, 16'h0000});
    frame({8'h00, resolver_pkg::ADDR_WR_FIRST, 16'h0001});
    chk({16'h0, lim_first}, 32'h8fc0);
  endtask
  task t_straps;
    pins(9'h03f);
    chk({29'h0, osc_sel, res_12b, accel_en}, 32'h3);
    pins(9'h032);
    chk({29'h0, osc_sel, res_12b, accel_en}, 32'h4);
  endtask
  task t_par;
    angle <= 12'habd;
    pins(9'h036);
    chk({20'h0, lnk.parallel_word_out[11:0]}, 32'habd);
    pins(9'h0b6);
    chk({20'h0, lnk.parallel_word_out[11:0]}, 32'h567);
    pins(9'h1b6);
    chk({20'h0, lnk.parallel_word_out[11:0]}, 32'h0);
    pins(9'h032);
    chk({20'h0, lnk.parallel_word_out[11:0]}, 32'habc);
    pins(9'h016);
    angle <= 12'h002;
    settle;
    chk({20'h0, lnk.parallel_word_out[11:0]}, 32'habc);
    pins(9'h076);
    chk({29'h0, lnk.quadrature_a_out, lnk.quadrature_b_out, lnk.index_pulse_out}, 32'h6);
    angle <= 12'h000;
    settle;
    chk({29'h0, lnk.quadrature_a_out, lnk.quadrature_b_out, lnk.index_pulse_out}, 32'h1);
    pins(9'h032);
  endtask
  task t_fault;
    pulse;
    chk({31'h0, lnk.fault_level}, 32'h1);
    rreg(resolver_pkg::HOFS_STAT, v);
    chk({31'h0, v[2]}, 32'h1);
    pins(9'h030);
    pins(9'h032);
    chk({31'h0, lnk.fault_level}, 32'h0);
    pins(9'h030);
    pulse;
    chk({31'h0, lnk.fault_level}, 32'h0);
    pins(9'h032);
  endtask
  task t_core;
    pins(9'h022);
    chk({15'h0, core_rst, lim_first}, 32'h10000);
    pins(9'h032);
    chk({31'h0, core_rst}, 32'h0);
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset;
    t_lock;
    t_straps;
    t_par;
    t_fault;
    t_core;
    test_done;
  end

  // Runs last about 12k cycles; this cuts a hung frame short
  initial begin
    #300000;
    miscompares++;
    test_done;
  end
endmodule
